// >>> sfa_otp_access.sv
// command logic of a serial flash with a lockable otp sector
`timescale 1ns/100ps
module sfa_otp_access
  import sfa_pkg::*;
#(
  parameter int PUW_CYCLES = PUW_CYC,
  parameter int WSR_CYCLES = WSR_CYC,
  parameter int PP_CYCLES = PP_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic di_i,
  output logic do_o,
  output logic do_oe,
  // main array port
  output sfa_arr_t arr_o,
  input wire logic [7:0] arr_rd_data,
  // status
  output logic otp_mode_o,
  output logic otp_lock_o,
  output logic deep_sleep_o,
  output logic busy_o,
  output logic write_ready_o
);

  localparam int CNT_MAX = (1 << CNT_W) - 1;
  if (PUW_CYCLES < 1 || WSR_CYCLES < 1 || PP_CYCLES < 1 || ERASE_CYCLES < 1) begin : g_bad_min
    $error("timing counts must be at least one cycle");
  end
  if (PUW_CYCLES > CNT_MAX || WSR_CYCLES > CNT_MAX || PP_CYCLES > CNT_MAX
      || ERASE_CYCLES > CNT_MAX) begin : g_bad_max
    $error("timing counts exceed the counter width");
  end
  if (WSR_CYCLES > WSR_MAX_CYC) begin : g_bad_wsr
    $error("status write cycle longer than its maximum");
  end

  sfa_rx_t rx;
  logic [7:0] tx_byte;

  sfa_spi_rx u_rx (
    .clk(clk),
    .srst(srst),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .di_i(di_i),
    .do_o(do_o),
    .do_oe(do_oe),
    .tx_byte(tx_byte),
    .rx_o(rx)
  );

  sfa_pw_t pw_r, pw_nxt;
  logic [CNT_W-1:0] pw_cnt_r, pw_cnt_nxt;
  logic busy_r, busy_nxt;
  logic [CNT_W-1:0] busy_cnt_r, busy_cnt_nxt;
  logic wel_r, wel_nxt;
  logic [3:0] blk_prot_r, blk_prot_nxt;
  logic prot_r, prot_nxt;
  logic otp_r, otp_nxt;
  logic lock_r, lock_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [7:0] wsr_data_r, wsr_data_nxt;
  logic prog_ok_r, prog_ok_nxt;
  logic programmed_r, programmed_nxt;
  sfa_arr_t arr_r, arr_nxt;
  logic [7:0] mem_r [OTP_BYTES];
  logic [7:0] mem_nxt [OTP_BYTES];
  logic writes_open;
  logic [7:0] status_view;
  logic [7:0] read_byte;

  function automatic logic in_top(input logic [23:0] a);
    return a[23:12] == TOP_SECTOR;
  endfunction : in_top

  function automatic logic in_otp(input logic [23:0] a);
    return (a >= OTP_BASE) && (a <= OTP_LAST);
  endfunction : in_otp

  // program or erase permission for one address
  function automatic logic may_write(input logic [23:0] a, input logic otp,
                                     input logic lock, input logic [3:0] blk);
    logic ok;
    ok = 1'b1;
    if (otp) begin
      if (in_otp(a)) begin
        ok = !lock && (blk == BLK_NONE);
      end else if (in_top(a)) begin
        ok = 1'b0;
      end else begin
        ok = !lock;
      end
    end
    return ok;
  endfunction : may_write

  assign writes_open = (pw_r == PW_STBY) && !busy_r;

  // status bit 7 swaps to the lock flag in otp mode
  always_comb begin
    status_view = STATUS_RESET;
    status_view[ST_BUSY_POS] = busy_r;
    status_view[ST_WEL_POS] = wel_r;
    status_view[ST_BLK_LSB +: 4] = blk_prot_r;
    status_view[ST_PROT_POS] = otp_r ? lock_r : prot_r;
  end

  // otp overlay in the top sector
  always_comb begin
    if (otp_r && in_top(addr_r)) begin
      read_byte = in_otp(addr_r) ? mem_r[addr_r[8:0]] : ERASED_BYTE;
    end else begin
      read_byte = arr_rd_data;
    end
  end

  always_comb begin
    if (pw_r == PW_SLEEP || pw_r == PW_SLEEP_WAIT || pw_r == PW_WAKE) begin
      // id stays readable by the release instruction while asleep
      tx_byte = (cmd_r == CMD_SLEEP_RELEASE) ? DEVICE_ID : ERASED_BYTE;
    end else begin
      case (cmd_r)
        CMD_READ_STATUS: tx_byte = status_view;
        CMD_READ_DATA: tx_byte = read_byte;
        CMD_SLEEP_RELEASE: tx_byte = DEVICE_ID;
        default: tx_byte = ERASED_BYTE;
      endcase
    end
  end

  always_comb begin
    pw_nxt = pw_r;
    pw_cnt_nxt = pw_cnt_r;
    busy_nxt = busy_r;
    busy_cnt_nxt = busy_cnt_r;
    wel_nxt = wel_r;
    blk_prot_nxt = blk_prot_r;
    prot_nxt = prot_r;
    otp_nxt = otp_r;
    lock_nxt = lock_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    wsr_data_nxt = wsr_data_r;
    prog_ok_nxt = prog_ok_r;
    programmed_nxt = programmed_r;
    mem_nxt = mem_r;
    arr_nxt = arr_r;
    arr_nxt.wr = 1'b0;
    arr_nxt.erase = 1'b0;
    arr_nxt.addr = addr_r;

    // power state timers
    case (pw_r)
      PW_BOOT: begin
        if (pw_cnt_r <= CNT_W'(1)) begin
          pw_nxt = PW_STBY;
        end
      end
      PW_SLEEP_WAIT: begin
        if (pw_cnt_r <= CNT_W'(1)) begin
          pw_nxt = PW_SLEEP;
        end
      end
      PW_WAKE: begin
        if (pw_cnt_r <= CNT_W'(1)) begin
          pw_nxt = PW_STBY;
        end
      end
      PW_STBY, PW_SLEEP: begin
      end
      default: pw_nxt = PW_BOOT;
    endcase
    if (pw_cnt_r != '0) begin
      pw_cnt_nxt = pw_cnt_r - CNT_W'(1);
    end

    // internal write cycle
    if (busy_r) begin
      if (busy_cnt_r <= CNT_W'(1)) begin
        busy_nxt = 1'b0;
        wel_nxt = 1'b0;
      end
      busy_cnt_nxt = busy_cnt_r - CNT_W'(1);
    end

    if (rx.start) begin
      cmd_nxt = 8'h00;
      programmed_nxt = 1'b0;
      prog_ok_nxt = 1'b0;
    end

    // byte collection
    if (rx.byte_ok) begin
      if (rx.idx == 8'd0) begin
        cmd_nxt = rx.data;
      end else if (cmd_r == CMD_WRITE_STATUS && rx.idx == 8'd1) begin
        wsr_data_nxt = rx.data;
      end else if (rx.idx <= 8'd3) begin
        addr_nxt = {addr_r[15:0], rx.data};
        if (rx.idx == 8'd3) begin
          prog_ok_nxt = wel_r && writes_open
                        && may_write({addr_r[15:0], rx.data}, otp_r, lock_r, blk_prot_r);
        end
      end else if (cmd_r == CMD_READ_DATA) begin
        addr_nxt = addr_r + 24'h00_0001;
      end else if (cmd_r == CMD_PAGE_PROGRAM && prog_ok_r) begin
        programmed_nxt = 1'b1;
        if (otp_r && in_otp(addr_r)) begin
          mem_nxt[addr_r[8:0]] = mem_r[addr_r[8:0]] & rx.data;
        end else begin
          arr_nxt.wr = 1'b1;
          arr_nxt.wdata = rx.data;
        end
        addr_nxt = {addr_r[23:8], addr_r[7:0] + 8'h01};
      end
    end

    // execution on chip select release
    if (rx.stop && rx.clean) begin
      if (pw_r == PW_SLEEP) begin
        if (cmd_r == CMD_SLEEP_RELEASE && rx.count != 8'd0) begin
          pw_nxt = PW_WAKE;
          pw_cnt_nxt = (rx.count == 8'd1) ? CNT_W'(RES1_CYC) : CNT_W'(RES2_CYC);
        end
      end else if ((pw_r == PW_STBY || pw_r == PW_BOOT) && !busy_r) begin
        case (cmd_r)
          CMD_WRITE_ENABLE: begin
            if (rx.count == 8'd1 && writes_open) begin
              wel_nxt = 1'b1;
            end
          end
          CMD_WRITE_DISABLE: begin
            if (rx.count == 8'd1) begin
              wel_nxt = 1'b0;
              otp_nxt = 1'b0;
            end
          end
          CMD_ENTER_OTP: begin
            if (rx.count == 8'd1) begin
              otp_nxt = 1'b1;
            end
          end
          CMD_WRITE_STATUS: begin
            if (rx.count == 8'd2 && wel_r && writes_open) begin
              if (otp_r) begin
                lock_nxt = 1'b1;
              end else begin
                blk_prot_nxt = wsr_data_r[ST_BLK_LSB +: 4];
                prot_nxt = wsr_data_r[ST_PROT_POS];
              end
              busy_nxt = 1'b1;
              busy_cnt_nxt = CNT_W'(WSR_CYCLES);
            end
          end
          CMD_PAGE_PROGRAM: begin
            if (programmed_r) begin
              busy_nxt = 1'b1;
              busy_cnt_nxt = CNT_W'(PP_CYCLES);
            end
          end
          CMD_SECTOR_ERASE: begin
            if (rx.count == 8'd4 && prog_ok_r) begin
              if (otp_r && in_otp(addr_r)) begin
                for (int i = 0; i < OTP_BYTES; i++) begin
                  mem_nxt[i] = ERASED_BYTE;
                end
              end else begin
                arr_nxt.erase = 1'b1;
                arr_nxt.kind = ERASE_SECTOR;
              end
              busy_nxt = 1'b1;
              busy_cnt_nxt = CNT_W'(ERASE_CYCLES);
            end
          end
          CMD_BLOCK_ERASE: begin
            // block number sits in address bits 21:16
            if (rx.count == 8'd4 && prog_ok_r
                && !(otp_r && addr_r[21:16] == TOP_BLOCK)) begin
              arr_nxt.erase = 1'b1;
              arr_nxt.kind = ERASE_BLOCK;
              busy_nxt = 1'b1;
              busy_cnt_nxt = CNT_W'(ERASE_CYCLES);
            end
          end
          CMD_CHIP_ERASE, CMD_CHIP_ERASE_ALT: begin
            if (rx.count == 8'd1 && wel_r && writes_open && !otp_r
                && blk_prot_r == BLK_NONE) begin
              arr_nxt.erase = 1'b1;
              arr_nxt.kind = ERASE_CHIP;
              busy_nxt = 1'b1;
              busy_cnt_nxt = CNT_W'(ERASE_CYCLES);
            end
          end
          CMD_DEEP_SLEEP: begin
            if (rx.count == 8'd1 && pw_r == PW_STBY) begin
              pw_nxt = PW_SLEEP_WAIT;
              pw_cnt_nxt = CNT_W'(SLEEP_CYC);
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pw_r <= PW_BOOT;
      pw_cnt_r <= CNT_W'(PUW_CYCLES);
      busy_r <= 1'b0;
      busy_cnt_r <= '0;
      wel_r <= STATUS_RESET[ST_WEL_POS];
      blk_prot_r <= STATUS_RESET[ST_BLK_LSB +: 4];
      prot_r <= STATUS_RESET[ST_PROT_POS];
      otp_r <= 1'b0;
      lock_r <= 1'b0;
      cmd_r <= 8'h00;
      addr_r <= 24'h00_0000;
      wsr_data_r <= 8'h00;
      prog_ok_r <= 1'b0;
      programmed_r <= 1'b0;
      arr_r <= '0;
      for (int i = 0; i < OTP_BYTES; i++) begin
        mem_r[i] <= ERASED_BYTE;
      end
    end else begin
      pw_r <= pw_nxt;
      pw_cnt_r <= pw_cnt_nxt;
      busy_r <= busy_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      wel_r <= wel_nxt;
      blk_prot_r <= blk_prot_nxt;
      prot_r <= prot_nxt;
      otp_r <= otp_nxt;
      lock_r <= lock_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      wsr_data_r <= wsr_data_nxt;
      prog_ok_r <= prog_ok_nxt;
      programmed_r <= programmed_nxt;
      arr_r <= arr_nxt;
      mem_r <= mem_nxt;
    end
  end

  assign arr_o = arr_r;
  assign otp_mode_o = otp_r;
  assign otp_lock_o = lock_r;
  assign deep_sleep_o = (pw_r == PW_SLEEP);
  assign busy_o = busy_r;
  assign write_ready_o = writes_open;

endmodule : sfa_otp_access

// >>> sfa_pkg.sv
// shared constants, types and timing for the otp sector access block
package sfa_pkg;

  // instruction codes
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_READ_DATA = 8'h03;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_ENTER_OTP = 8'h3a;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] CMD_CHIP_ERASE_ALT = 8'h60;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] CMD_DEEP_SLEEP = 8'hb9;
  localparam logic [7:0] CMD_SLEEP_RELEASE = 8'hab;

  // status register layout and values after reset
  localparam int ST_BUSY_POS = 0;
  localparam int ST_WEL_POS = 1;
  localparam int ST_BLK_LSB = 2;
  localparam int ST_PROT_POS = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [3:0] BLK_NONE = 4'h0;

  // array layout
  localparam logic [23:0] OTP_BASE = 24'h3f_f000;
  localparam logic [23:0] OTP_LAST = 24'h3f_f1ff;
  localparam logic [11:0] TOP_SECTOR = 12'h3ff;
  localparam logic [5:0] TOP_BLOCK = 6'h3f;
  localparam int OTP_BYTES = 512;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] DEVICE_ID = 8'h5a; // arbitrary value

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_PUW_MS = 1;
  localparam int T_WSR_TYP_MS = 15;
  localparam int T_WSR_MAX_MS = 50;
  localparam int T_PP_TYP_US = 1300;
  localparam int T_ERASE_TYP_MS = 90;
  localparam int T_SLEEP_NS = 3000;
  localparam int T_RES1_NS = 3000;
  localparam int T_RES2_NS = 1800;
  // chip select pin rise to execution, in cycles, taken off the sleep and release timers
  localparam int CS_LAT_CYC = 4;
  localparam int PUW_CYC = (T_PUW_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WSR_CYC = T_WSR_TYP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WSR_MAX_CYC = T_WSR_MAX_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PP_CYC = T_PP_TYP_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_CYC = T_ERASE_TYP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SLEEP_CYC = T_SLEEP_NS / CLK_PERIOD_NS - CS_LAT_CYC;
  localparam int RES1_CYC = T_RES1_NS / CLK_PERIOD_NS - CS_LAT_CYC;
  localparam int RES2_CYC = T_RES2_NS / CLK_PERIOD_NS - CS_LAT_CYC;
  localparam int CNT_W = 24;

  // erase kinds on the array port
  localparam logic [1:0] ERASE_SECTOR = 2'h0;
  localparam logic [1:0] ERASE_BLOCK = 2'h1;
  localparam logic [1:0] ERASE_CHIP = 2'h2;

  typedef enum logic [2:0] {
    PW_BOOT = 3'b000,
    PW_STBY = 3'b001,
    PW_SLEEP_WAIT = 3'b011,
    PW_SLEEP = 3'b010,
    PW_WAKE = 3'b110
  } sfa_pw_t;

  typedef struct packed {
    logic sel;
    logic start;
    logic stop;
    logic byte_ok;
    logic clean;
    logic [7:0] data;
    logic [7:0] idx;
    logic [7:0] count;
  } sfa_rx_t;

  typedef struct packed {
    logic wr;
    logic erase;
    logic [1:0] kind;
    logic [23:0] addr;
    logic [7:0] wdata;
  } sfa_arr_t;

endpackage : sfa_pkg

// >>> sfa_spi_rx.sv
// serial front end: pin synchronisers, byte assembly and output shifter
`timescale 1ns/100ps
module sfa_spi_rx
  import sfa_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic di_i,
  output logic do_o,
  output logic do_oe,
  // core side
  input wire logic [7:0] tx_byte,
  output sfa_rx_t rx_o
);

  logic [2:0] sck_q;
  logic [2:0] cs_q;
  logic [1:0] di_q;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] shin_r, shin_nxt;
  logic [7:0] shout_r, shout_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  sfa_rx_t rx_r, rx_nxt;
  logic rise, fall;

  // only stage [1] and later feed logic
  assign rise = sck_q[1] & ~sck_q[2];
  assign fall = ~sck_q[1] & sck_q[2];

  always_comb begin
    bit_nxt = bit_r;
    shin_nxt = shin_r;
    shout_nxt = shout_r;
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    rx_nxt.sel = ~cs_q[1];
    rx_nxt.start = ~cs_q[1] & cs_q[2];
    rx_nxt.stop = cs_q[1] & ~cs_q[2];
    rx_nxt.byte_ok = 1'b0;
    rx_nxt.clean = (bit_r == 3'd0);
    rx_nxt.count = cnt_r;
    if (rx_nxt.start) begin
      bit_nxt = 3'd0;
      cnt_nxt = 8'h00;
      rx_nxt.count = 8'h00;
    end else if (~cs_q[1] && rise) begin
      shin_nxt = {shin_r[6:0], di_q[1]};
      bit_nxt = bit_r + 3'd1;
      if (bit_r == 3'd7) begin
        rx_nxt.byte_ok = 1'b1;
        rx_nxt.data = {shin_r[6:0], di_q[1]};
        rx_nxt.idx = cnt_r;
        if (cnt_r != 8'hff) begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
    end else if (~cs_q[1] && fall) begin
      if (bit_r == 3'd0) begin
        shout_nxt = tx_byte;
      end else begin
        shout_nxt = {shout_r[6:0], 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sck_q <= 3'b000;
      cs_q <= 3'b111;
      di_q <= 2'b00;
      bit_r <= 3'd0;
      shin_r <= 8'h00;
      shout_r <= 8'hff;
      cnt_r <= 8'h00;
      rx_r <= '0;
    end else begin
      sck_q <= {sck_q[1:0], sclk_i};
      cs_q <= {cs_q[1:0], cs_n_i};
      di_q <= {di_q[0], di_i};
      bit_r <= bit_nxt;
      shin_r <= shin_nxt;
      shout_r <= shout_nxt;
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
    end
  end

  assign do_o = shout_r[7];
  assign do_oe = rx_r.sel;
  assign rx_o = rx_r;

endmodule : sfa_spi_rx

// >>> sfa_otp_access_asserts.sv
// port checks for the otp sector access block
`timescale 1ns/100ps
module sfa_otp_access_asserts
  import sfa_pkg::*;
#(
  parameter int PUW_CYCLES = PUW_CYC,
  parameter int WSR_CYCLES = WSR_CYC,
  parameter int PP_CYCLES = PP_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic di_i,
  input wire logic do_o,
  input wire logic do_oe,
  // array port
  input wire sfa_arr_t arr_o,
  input wire logic [7:0] arr_rd_data,
  // status
  input wire logic otp_mode_o,
  input wire logic otp_lock_o,
  input wire logic deep_sleep_o,
  input wire logic busy_o,
  input wire logic write_ready_o
);
  logic [31:0] puw_cnt_r;
  logic [31:0] puw_cnt_nxt;
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;
  logic arr_act;

  assign arr_act = arr_o.wr | arr_o.erase;

  always_comb begin
    puw_cnt_nxt = puw_cnt_r;
    if (puw_cnt_r < PUW_CYCLES) puw_cnt_nxt = puw_cnt_r + 32'h0000_0001;
    busy_cnt_nxt = busy_o ? busy_cnt_r + 32'h0000_0001 : 32'h0000_0000;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      puw_cnt_r <= 32'h0000_0000;
      busy_cnt_r <= 32'h0000_0000;
    end else begin
      puw_cnt_r <= puw_cnt_nxt;
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_ready_delay: assert property ((write_ready_o || busy_o) |-> puw_cnt_r == PUW_CYCLES)
    else $error("write accepted before power-up delay");
  a_busy_length: assert property ($fell(busy_o) |-> busy_cnt_r == WSR_CYCLES ||
    busy_cnt_r == PP_CYCLES || busy_cnt_r == ERASE_CYCLES)
    else $error("internal cycle length wrong");
  a_lock_stays: assert property (otp_lock_o |=> otp_lock_o)
    else $error("lock flag cleared");
  a_lock_sets_busy: assert property ($rose(otp_lock_o) |-> busy_o && otp_mode_o)
    else $error("lock set outside status write");
  a_lock_gate: assert property (otp_mode_o && otp_lock_o |-> !arr_act)
    else $error("array written while locked");
  a_top_sector: assert property (otp_mode_o && arr_act |-> arr_o.addr[23:12] != TOP_SECTOR)
    else $error("top sector reached array in otp mode");
  a_erase_kind: assert property (otp_mode_o && arr_o.erase |-> arr_o.kind == ERASE_SECTOR ||
    (arr_o.kind == ERASE_BLOCK && arr_o.addr[21:16] != TOP_BLOCK))
    else $error("wrong erase kind in otp mode");
  a_mode_at_cs: assert property ($changed(otp_mode_o) |-> cs_n_i && $past(cs_n_i, 2))
    else $error("otp mode changed while selected");
  a_sleep_at_cs: assert property ($changed(deep_sleep_o) |-> cs_n_i)
    else $error("sleep changed while selected");
  a_sleep_quiet: assert property (deep_sleep_o |-> !busy_o && !arr_act)
    else $error("write activity in deep sleep");

  c_lock: cover property ($rose(otp_lock_o));
  c_exit: cover property ($fell(otp_mode_o));
  c_sleep: cover property ($fell(deep_sleep_o));
  c_otp_wr: cover property (otp_mode_o && arr_o.wr);
endmodule : sfa_otp_access_asserts

bind sfa_otp_access sfa_otp_access_asserts #(.PUW_CYCLES(PUW_CYCLES),
  .WSR_CYCLES(WSR_CYCLES), .PP_CYCLES(PP_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_chk (
  .clk(clk), .srst(srst), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .di_i(di_i), .do_o(do_o),
  .do_oe(do_oe), .arr_o(arr_o), .arr_rd_data(arr_rd_data), .otp_mode_o(otp_mode_o),
  .otp_lock_o(otp_lock_o), .deep_sleep_o(deep_sleep_o), .busy_o(busy_o),
  .write_ready_o(write_ready_o));

// >>> sfa_host_model.sv
// spi host model issuing whole-byte frames, mode 0
`timescale 1ns/100ps
module sfa_host_model
  import sfa_pkg::*;
(
  // clock
  input wire logic clk,
  // serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic di_o,
  input wire logic do_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    di_o = 1'b0;
  end

  // bytes leave from tx[63:56] down; bits seen on do land at the same spots of rx
  task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    @(posedge clk);
    #13;
    cs_n_o = 1'b0;
    #400;
    for (int i = 0; i < n * 8; i++) begin
      di_o = tx[63-i];
      #400 sclk_o = 1'b1;
      // sample just before the fall that shifts the next bit
      #400 rx[63-i] = do_i;
      sclk_o = 1'b0;
    end
    #400 cs_n_o = 1'b1;
    // released data line must not keep its last value
    di_o = ~di_o;
    repeat (6) @(posedge clk);
    #13;
  endtask : frame
endmodule : sfa_host_model

// >>> sfa_otp_access_tb.sv
// self-checking bench for the otp sector access block
`timescale 1ns/100ps
`define CHK(nm, exp, act) begin check_count++; if ((act) !== (exp)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, exp, act); end end
module sfa_otp_access_tb
  import sfa_pkg::*;
;
  logic clk;
  logic srst;
  logic sclk;
  logic cs_n;
  logic di;
  logic do_o;
  logic do_oe;
  sfa_arr_t arr;
  sfa_arr_t last_wr = '0;
  logic [7:0] arr_rd_data;
  logic otp_mode, otp_lock, deep_sleep, busy, write_ready;
  logic [2:0] flags;
  logic [63:0] rx;
  logic [63:0] ers [3] = '{64'hd83f_0000_0000_0000, 64'hc700_0000_0000_0000,
    64'h6000_0000_0000_0000};
  int ern [3] = '{4, 1, 1};
  int error_cnt;
  int check_count;
  int wr_cnt;

  // array model: contents depend on address so a wrong address shows
  assign arr_rd_data = arr.addr[7:0] ^ 8'h5c;
  assign flags = {write_ready, deep_sleep, busy};

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  sfa_host_model u_host (.clk(clk), .sclk_o(sclk), .cs_n_o(cs_n), .di_o(di), .do_i(do_o));

  sfa_otp_access #(.PUW_CYCLES(20), .WSR_CYCLES(40), .PP_CYCLES(10), .ERASE_CYCLES(30)) u_dut (
    .clk(clk), .srst(srst), .sclk_i(sclk), .cs_n_i(cs_n), .di_i(di), .do_o(do_o),
    .do_oe(do_oe), .arr_o(arr), .arr_rd_data(arr_rd_data), .otp_mode_o(otp_mode),
    .otp_lock_o(otp_lock), .deep_sleep_o(deep_sleep), .busy_o(busy),
    .write_ready_o(write_ready));

  always @(posedge clk) begin
    if (arr.wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      last_wr <= arr;
    end
  end

  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic sf(input int n, input logic [63:0] tx);
    u_host.frame(n, tx, rx);
  endtask : sf

  task automatic wr(input int n, input logic [63:0] tx);
    sf(1, 64'h0600_0000_0000_0000);
    sf(n, tx);
  endtask : wr

  // sel 0 busy, 1 deep sleep, 2 write ready
  task automatic wait_sig(input int sel, input logic v, input int lim);
    for (int k = 0; k < lim && flags[sel] !== v; k++) begin
      @(posedge clk);
      #13;
    end
    if (flags[sel] !== v) begin
      error_cnt++;
      $display("Error flag %0d expected %h seen %h", sel, v, flags[sel]);
      wrap_up();
    end
  endtask : wait_sig

  task automatic rd(input logic [23:0] a, input logic [7:0] e0, input logic [7:0] e1);
    sf(6, {8'h03, a, 32'h0000_0000});
    `CHK("read byte 0", e0, rx[31:24])
    `CHK("read byte 1", e1, rx[23:16])
  endtask : rd

  task automatic st(input logic [7:0] e);
    sf(2, 64'h0500_0000_0000_0000);
    `CHK("status", e, rx[55:48])
  endtask : st

  initial begin
    srst = 1'b1;
    repeat (3) @(posedge clk);
    #13;
    `CHK("mode after reset", 2'b00, {otp_mode, otp_lock})
    `CHK("flags after reset", 4'h0, {busy, deep_sleep, write_ready, do_oe})
    srst = 1'b0;
    wait_sig(2, 1'b1, 40);
    st(8'h00);
    rd(24'h3f_f000, 8'h5c, 8'h5d);
    wr(2, 64'h0104_0000_0000_0000);
    `CHK("status write busy", 1'b1, busy)
    wait_sig(0, 1'b0, 200);
    st(8'h04);
    sf(1, 64'h3a00_0000_0000_0000);
    `CHK("otp entry", 1'b1, otp_mode)
    wr(5, 64'h023f_f000_a500_0000);
    `CHK("protected otp program", 1'b0, busy)
    sf(1, 64'h0400_0000_0000_0000);
    `CHK("otp exit", 1'b0, otp_mode)
    wr(2, 64'h0100_0000_0000_0000);
    wait_sig(0, 1'b0, 200);
    sf(1, 64'h3a00_0000_0000_0000);
    wr(5, 64'h023f_f000_a500_0000);
    `CHK("otp program", 1'b1, busy)
    wait_sig(0, 1'b0, 200);
    rd(24'h3f_f000, 8'ha5, 8'hff);
    for (int i = 0; i < 3; i++) begin
      wr(ern[i], ers[i]);
      `CHK("other erase", 1'b0, busy)
    end
    wr(4, 64'h203f_f000_0000_0000);
    `CHK("otp sector erase", 1'b1, busy)
    wait_sig(0, 1'b0, 200);
    rd(24'h3f_f000, 8'hff, 8'hff);
    wr(5, 64'h0200_0010_3300_0000);
    `CHK("ordinary program", {1'b1, 24'h00_0010, 8'h33}, {wr_cnt[0], last_wr.addr, last_wr.wdata})
    wait_sig(0, 1'b0, 200);
    rd(24'h00_0000, 8'h5c, 8'h5d);
    wr(2, 64'h01ff_0000_0000_0000);
    `CHK("lock set", 1'b1, otp_lock)
    wait_sig(0, 1'b0, 200);
    st(8'h80);
    wr(5, 64'h023f_f000_0000_0000);
    `CHK("locked otp program", 1'b0, busy)
    wr(5, 64'h0200_0010_0000_0000);
    `CHK("locked array program", 1, wr_cnt)
    sf(1, 64'h0400_0000_0000_0000);
    `CHK("exit keeps lock", 2'b01, {otp_mode, otp_lock})
    rd(24'h3f_f000, 8'h5c, 8'h5d);
    st(8'h00);
    // frame returns 6 cycles after chip select rises; bounds are the rest of 3 us and 1.8 us
    sf(1, 64'hb900_0000_0000_0000);
    wait_sig(1, 1'b1, 24);
    sf(5, 64'hab00_0000_0000_0000);
    `CHK("device id", DEVICE_ID, rx[31:24])
    wait_sig(2, 1'b1, 12);
    sf(1, 64'hb900_0000_0000_0000);
    wait_sig(1, 1'b1, 24);
    sf(1, 64'hab00_0000_0000_0000);
    wait_sig(2, 1'b1, 24);
    repeat (30) @(posedge clk);
    wrap_up();
  end
endmodule : sfa_otp_access_tb
